//--- core/csso_core.sv
// Stack pointer, stack traffic, standby and table unit of the core.
`timescale 1ns/1ps
module csso_core
  import csso_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [3:0]  cmd_op,
  input  wire logic [1:0]  cmd_size,
  input  wire logic [31:0] cmd_data,
  input  wire logic [31:0] cmd_aux,
  input  wire logic [2:0]  irq_level,
  output logic             rsp_valid,
  output logic [31:0]      rsp_data,
  output logic [7:0]       rsp_frac,
  output logic             unimpl_trap,
  output logic             low_power,
  output logic             supervisor,
  output logic [31:0]      addr_reg_seven,
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic             mem_ube,
  output logic             mem_lbe,
  output logic [15:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata
);

  csso_state_t state_r, state_nxt;
  csso_op_t    op_r, op_nxt;
  logic [1:0]  size_r, size_nxt;
  logic [31:0] ssp_r, ssp_nxt, usp_r, usp_nxt, addr_r, addr_nxt;
  logic [15:0] sw_r, sw_nxt;
  logic [63:0] buf_r, buf_nxt;
  logic [2:0]  cnt_r, cnt_nxt, lvl_r, lvl_nxt;
  logic [8:0]  aux_r, aux_nxt;
  logic        req_r, req_nxt, we_r, we_nxt, ube_r, ube_nxt;
  logic        lbe_r, lbe_nxt, rv_r, rv_nxt, trap_r, trap_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [7:0]  rf_r, rf_nxt;

  logic [31:0] sp_cur, sp_new, step, bytes, exc_pc;
  logic [63:0] fin;
  logic        sp_wr, exc_go;
  logic [31:0] ent_lo, ent_hi, ip_res;
  logic [7:0]  ip_frac;

  function automatic logic [31:0] stk_bytes(input logic [1:0] sz);
    // RULE7 bytes still move a whole word
    stk_bytes = (sz == SZ_LONG) ? STK_STEP_LONG : STK_STEP_WORD;
  endfunction : stk_bytes

  function automatic logic [31:0] sext8(input logic [7:0] b);
    sext8 = {{24{b[7]}}, b};
  endfunction : sext8

  function automatic logic [31:0] sext16(input logic [15:0] w);
    sext16 = {{16{w[15]}}, w};
  endfunction : sext16

  // RULE1 register seven reads the active pointer
  // RULE2 other pointer is hidden
  assign sp_cur         = sw_r[SW_SUP_BIT] ? ssp_r : usp_r;
  assign addr_reg_seven = sp_cur;
  assign supervisor     = sw_r[SW_SUP_BIT];
  assign low_power      = (state_r == ST_HALT);
  assign cmd_ready      = (state_r == ST_IDLE);
  assign rsp_valid      = rv_r;
  assign rsp_data       = rd_r;
  assign rsp_frac       = rf_r;
  assign unimpl_trap    = trap_r;
  assign mem_req        = req_r;
  assign mem_we         = we_r;
  assign mem_addr       = addr_r;
  assign mem_ube        = ube_r;
  assign mem_lbe        = lbe_r;
  assign mem_wdata      = buf_r[63:48];

  assign fin = {buf_r[47:0], mem_rdata};

  // Byte entries sit in the lane picked by address parity.
  always_comb
  begin
    unique case (size_r)
      SZ_BYTE:
      begin
        ent_lo = sext8(addr_r[0] ? fin[31:24] : fin[23:16]);
        ent_hi = sext8(addr_r[0] ? fin[7:0] : fin[15:8]);
      end
      SZ_WORD:
      begin
        ent_lo = sext16(fin[31:16]);
        ent_hi = sext16(fin[15:0]);
      end
      default:
      begin
        ent_lo = fin[63:32];
        ent_hi = fin[31:0];
      end
    endcase
  end

  csso_interp u_interp (
    .entry_lo   (ent_lo),
    .entry_hi   (ent_hi),
    .frac       (aux_r[FRAC_W-1:0]),
    .size       (size_r),
    .round_near (aux_r[AUX_ROUND_BIT]),
    .result     (ip_res),
    .frac_out   (ip_frac)
  );

  always_comb
  begin
    state_nxt = state_r;
    op_nxt    = op_r;
    size_nxt  = size_r;
    ssp_nxt   = ssp_r;
    usp_nxt   = usp_r;
    sw_nxt    = sw_r;
    buf_nxt   = buf_r;
    addr_nxt  = addr_r;
    cnt_nxt   = cnt_r;
    lvl_nxt   = lvl_r;
    aux_nxt   = aux_r;
    req_nxt   = req_r;
    we_nxt    = we_r;
    ube_nxt   = ube_r;
    lbe_nxt   = lbe_r;
    rd_nxt    = rd_r;
    rf_nxt    = rf_r;
    rv_nxt    = 1'b0;
    trap_nxt  = 1'b0;
    sp_wr     = 1'b0;
    sp_new    = sp_cur;
    exc_go    = 1'b0;
    exc_pc    = cmd_data;
    bytes     = stk_bytes(cmd_size);
    step      = (op_r == OP_TABLE && size_r == SZ_BYTE) ? 32'h1 : 32'h2;
    unique case (state_r)
      ST_IDLE:
      if (cmd_valid)
      begin
        op_nxt   = csso_op_t'(cmd_op);
        size_nxt = cmd_size;
        aux_nxt  = cmd_aux[8:0];
        ube_nxt  = 1'b1;
        lbe_nxt  = 1'b1;
        unique case (cmd_op)
          OP_PUSH, OP_CALL:
          begin
            if (cmd_op == OP_CALL)
            begin
              size_nxt = SZ_LONG;
              bytes    = STK_STEP_LONG;
            end
            // RULE3 push grows toward lower addresses
            // RULE4 pointer drops before the access
            sp_new   = sp_cur - bytes;
            sp_wr    = 1'b1;
            addr_nxt = sp_new;
            // RULE5 return address onto the active stack
            unique case (bytes == STK_STEP_LONG ? SZ_LONG : cmd_size)
              SZ_LONG: buf_nxt = {cmd_data, 32'h0};
              SZ_WORD: buf_nxt = {cmd_data[15:0], 48'h0};
              default: buf_nxt = {cmd_data[7:0], 56'h0};
            endcase
            // RULE7 byte push leaves the low half alone
            lbe_nxt   = (cmd_op == OP_CALL) || (cmd_size != SZ_BYTE);
            cnt_nxt   = (bytes == STK_STEP_LONG) ? 3'h2 : 3'h1;
            req_nxt   = 1'b1;
            we_nxt    = 1'b1;
            state_nxt = ST_WR;
          end
          OP_POP, OP_RET:
          begin
            if (cmd_op == OP_RET)
              size_nxt = SZ_LONG;
            addr_nxt  = sp_cur;
            cnt_nxt   = (cmd_op == OP_RET || cmd_size == SZ_LONG) ?
                        3'h2 : 3'h1;
            req_nxt   = 1'b1;
            we_nxt    = 1'b0;
            state_nxt = ST_RD;
          end
          OP_TRAP:
            exc_go = 1'b1;
          OP_HALT:
          begin
            // RULE9 enter standby, keeping the resume address
            lvl_nxt   = cmd_aux[2:0];
            buf_nxt   = {cmd_data, 32'h0};
            state_nxt = ST_HALT;
          end
          OP_TABLE:
          begin
            addr_nxt  = cmd_data;
            cnt_nxt   = (cmd_size == SZ_LONG) ? 3'h4 : 3'h2;
            req_nxt   = 1'b1;
            we_nxt    = 1'b0;
            state_nxt = ST_RD;
          end
          OP_DECODE:
          begin
            // RULE13 unimplemented line codes trap
            if (cmd_data[15:12] == LINE_A || cmd_data[15:12] == LINE_F)
            begin
              trap_nxt = 1'b1;
              exc_pc   = cmd_aux;
              exc_go   = 1'b1;
            end
            else
            begin
              // RULE8 brief word keeps scale, zero is unscaled
              rd_nxt = {29'h0, cmd_aux[EXT_FULL_BIT],
                        cmd_aux[EXT_SCALE_LSB+1:EXT_SCALE_LSB]};
              rv_nxt = 1'b1;
            end
          end
          OP_SETSW:
          begin
            sw_nxt = cmd_data[15:0];
            rv_nxt = 1'b1;
          end
          default:
          begin
            rd_nxt = 32'h0;
            rv_nxt = 1'b1;
          end
        endcase
      end
      ST_WR:
      if (mem_ack)
      begin
        buf_nxt  = {buf_r[47:0], 16'h0};
        addr_nxt = addr_r + STK_STEP_WORD;
        cnt_nxt  = cnt_r - 3'h1;
        if (cnt_r == 3'h1)
        begin
          req_nxt   = 1'b0;
          we_nxt    = 1'b0;
          rv_nxt    = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      ST_RD:
      if (mem_ack)
      begin
        buf_nxt  = fin;
        addr_nxt = addr_r + step;
        cnt_nxt  = cnt_r - 3'h1;
        if (cnt_r == 3'h1)
        begin
          req_nxt   = 1'b0;
          rv_nxt    = 1'b1;
          state_nxt = ST_IDLE;
          rf_nxt    = 8'h0;
          if (op_r == OP_TABLE)
          begin
            rd_nxt = ip_res;
            rf_nxt = ip_frac;
          end
          else
          begin
            // RULE4 pointer rises only after the read
            sp_new = sp_cur + stk_bytes(size_r);
            sp_wr  = 1'b1;
            unique case (size_r)
              SZ_LONG: rd_nxt = fin[31:0];
              SZ_WORD: rd_nxt = {16'h0, fin[15:0]};
              default: rd_nxt = {24'h0, fin[15:8]};
            endcase
          end
        end
      end
      ST_HALT:
      begin
        // RULE10 only an interrupt at or above the level wakes
        if (irq_level != 3'h0 && irq_level >= lvl_r)
        begin
          // RULE14 wake through normal interrupt stacking
          exc_pc = buf_r[63:32];
          exc_go = 1'b1;
        end
      end
    endcase
    if (sp_wr)
    begin
      if (sw_r[SW_SUP_BIT])
        ssp_nxt = sp_new;
      else
        usp_nxt = sp_new;
    end
    // RULE6 frame always goes on the supervisor stack
    if (exc_go)
    begin
      ssp_nxt   = ssp_r - EXC_FRAME_SZ;
      addr_nxt  = ssp_r - EXC_FRAME_SZ;
      buf_nxt   = {sw_r, exc_pc, 16'h0};
      sw_nxt[SW_SUP_BIT] = 1'b1;
      cnt_nxt   = EXC_FRAME_WDS;
      ube_nxt   = 1'b1;
      lbe_nxt   = 1'b1;
      req_nxt   = 1'b1;
      we_nxt    = 1'b1;
      state_nxt = ST_WR;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      state_r <= ST_IDLE;
      op_r    <= OP_PUSH;
      size_r  <= SZ_BYTE;
      ssp_r   <= SSP_RESET;
      usp_r   <= USP_RESET;
      sw_r    <= SW_RESET;
      buf_r   <= 64'h0;
      addr_r  <= 32'h0;
      cnt_r   <= 3'h0;
      lvl_r   <= 3'h0;
      aux_r   <= 9'h0;
      req_r   <= 1'b0;
      we_r    <= 1'b0;
      ube_r   <= 1'b0;
      lbe_r   <= 1'b0;
      rv_r    <= 1'b0;
      trap_r  <= 1'b0;
      rd_r    <= 32'h0;
      rf_r    <= 8'h0;
    end
    else
    begin
      state_r <= state_nxt;
      op_r    <= op_nxt;
      size_r  <= size_nxt;
      ssp_r   <= ssp_nxt;
      usp_r   <= usp_nxt;
      sw_r    <= sw_nxt;
      buf_r   <= buf_nxt;
      addr_r  <= addr_nxt;
      cnt_r   <= cnt_nxt;
      lvl_r   <= lvl_nxt;
      aux_r   <= aux_nxt;
      req_r   <= req_nxt;
      we_r    <= we_nxt;
      ube_r   <= ube_nxt;
      lbe_r   <= lbe_nxt;
      rv_r    <= rv_nxt;
      trap_r  <= trap_nxt;
      rd_r    <= rd_nxt;
      rf_r    <= rf_nxt;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  logic go;
  assign go = cmd_valid && cmd_ready;

  sequence s_frame_start;
    mem_req && mem_we && supervisor ##0 mem_wdata == $past(sw_r);
  endsequence

  property p_push_sel;
    go && cmd_op == OP_PUSH && supervisor |=>
      ssp_r == $past(ssp_r) - stk_bytes($past(cmd_size))
      && usp_r == $past(usp_r);
  endproperty
  a_push_sel: assert property (p_push_sel) // RULE2
    else $error("push did not use the supervisor pointer");

  property p_predec;
    go && cmd_op == OP_PUSH |=> mem_addr == addr_reg_seven && mem_we;
  endproperty
  a_predec: assert property (p_predec) // RULE4
    else $error("push address is not the decremented pointer");

  property p_postinc;
    state_r == ST_RD && mem_ack && cnt_r == 3'h1 && op_r == OP_POP
      |=> addr_reg_seven == $past(addr_reg_seven) + stk_bytes($past(size_r));
  endproperty
  a_postinc: assert property (p_postinc) // RULE4
    else $error("pop did not raise the pointer");

  property p_byte_half;
    mem_req && mem_we && !mem_lbe |-> mem_ube && mem_wdata[7:0] == 8'h0;
  endproperty
  a_byte_half: assert property (p_byte_half) // RULE7
    else $error("byte push not in upper half");

  property p_trap_frame;
    go && cmd_op == OP_TRAP |=> s_frame_start
      ##0 mem_addr == $past(ssp_r) - EXC_FRAME_SZ;
  endproperty
  a_trap_frame: assert property (p_trap_frame) // RULE6
    else $error("trap frame not on supervisor stack");

  property p_halt;
    go && cmd_op == OP_HALT |=> low_power;
  endproperty
  a_halt: assert property (p_halt) // RULE9
    else $error("halt did not enter standby");

  property p_stay;
    low_power && (irq_level == 3'h0 || irq_level < lvl_r) |=> low_power;
  endproperty
  a_stay: assert property (p_stay) // RULE10
    else $error("standby left without a qualifying interrupt");

  property p_wake;
    low_power && irq_level != 3'h0 && irq_level >= lvl_r
      |=> !low_power ##0 s_frame_start
          ##0 mem_addr == $past(ssp_r) - EXC_FRAME_SZ;
  endproperty
  a_wake: assert property (p_wake) // RULE14
    else $error("wake did not start interrupt stacking");

  property p_unimpl;
    go && cmd_op == OP_DECODE && cmd_data[15:12] == LINE_F
      |=> unimpl_trap ##1 !unimpl_trap;
  endproperty
  a_unimpl: assert property (p_unimpl) // RULE13
    else $error("unimplemented opcode did not trap");

  property p_scale0;
    go && cmd_op == OP_DECODE && cmd_data[15:12] != LINE_A
      && cmd_data[15:12] != LINE_F && cmd_aux[10:9] == 2'b00
      |=> rsp_valid && rsp_data[1:0] == 2'b00;
  endproperty
  a_scale0: assert property (p_scale0) // RULE8
    else $error("zero scale not reported as unscaled");

endmodule : csso_core

//--- core/csso_pkg.sv
// Constants and types shared by the stack and special-operation unit.
// What this block does
// RULE1 - Register seven is the system stack pointer.
// RULE2 - Supervisor flag selects supervisor or user pointer.
// RULE3 - System stack grows downward; push adds item.
// RULE4 - Predecrement before use, postincrement after use.
// RULE5 - Calls push PC; returns restore it.
// RULE6 - Traps, interrupts stack PC and status on supervisor.
// RULE7 - Stack moves whole words; bytes use upper half.
// RULE8 - Extension scale zero means plain unscaled index.
// RULE9 - Halt instruction enters low-power standby.
// RULE10 - Standby lasts until reset or qualifying interrupt.
// RULE11 - Table instruction interpolates two bounding entries.
// RULE12 - Round to nearest, or unrounded with fraction; long sizes are always rounded here.
// RULE13 - Unimplemented opcodes raise a trap.
// RULE14 - Wake-up runs normal interrupt stacking.
package csso_pkg;

  typedef enum logic [3:0] {
    OP_PUSH   = 4'b0000,
    OP_POP    = 4'b0001,
    OP_CALL   = 4'b0010,
    OP_RET    = 4'b0011,
    OP_TRAP   = 4'b0100,
    OP_HALT   = 4'b0101,
    OP_TABLE  = 4'b0110,
    OP_DECODE = 4'b0111,
    OP_SETSW  = 4'b1000
  } csso_op_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_LONG = 2'b10
  } csso_size_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WR   = 2'b01,
    ST_RD   = 2'b10,
    ST_HALT = 2'b11
  } csso_state_t;

  localparam logic [2:0]  SP_REG_NUM     = 3'h7;
  localparam int          SW_SUP_BIT     = 13;
  localparam logic [15:0] SW_RESET       = 16'h2700;
  localparam logic [31:0] SSP_RESET      = 32'h0;
  localparam logic [31:0] USP_RESET      = 32'h0;
  localparam logic [31:0] STK_STEP_WORD  = 32'h2;
  localparam logic [31:0] STK_STEP_LONG  = 32'h4;
  localparam logic [31:0] EXC_FRAME_SZ   = 32'h6;
  localparam logic [2:0]  EXC_FRAME_WDS  = 3'h3;
  localparam int          FRAC_W         = 8;
  localparam int          AUX_ROUND_BIT  = 8;
  localparam int          EXT_FULL_BIT   = 8;
  localparam int          EXT_SCALE_LSB  = 9;
  localparam logic [3:0]  LINE_A         = 4'ha;
  localparam logic [3:0]  LINE_F         = 4'hf;

endpackage : csso_pkg

//--- core/csso_interp.sv
// Linear interpolation between two table entries.
`timescale 1ns/1ps
module csso_interp
  import csso_pkg::*;
(
  input  wire logic [31:0]       entry_lo,
  input  wire logic [31:0]       entry_hi,
  input  wire logic [FRAC_W-1:0] frac,
  input  wire logic [1:0]        size,
  input  wire logic              round_near,
  output logic      [31:0]       result,
  output logic      [FRAC_W-1:0] frac_out
);

  logic signed [32:0] diff;
  logic signed [41:0] prod;
  logic signed [41:0] biased;
  logic               do_round;

  // RULE11 two-entry interpolation
  always_comb
  begin
    // RULE12 long results are always rounded
    do_round = round_near || (size == SZ_LONG);
    diff     = $signed({entry_hi[31], entry_hi})
             - $signed({entry_lo[31], entry_lo});
    prod     = 42'(diff * $signed({1'b0, frac}));
    biased   = do_round ? prod + 42'sh80 : prod;
    result   = entry_lo + 32'(biased >>> FRAC_W);
    frac_out = do_round ? '0 : prod[FRAC_W-1:0];
  end

endmodule : csso_interp

//--- verif/csso_mem_model.sv
// Behavioural memory that holds the stacks and the tables.
`timescale 1ns/1ps
module csso_mem_model (
  input  wire logic        ref_clk,
  input  wire logic [1:0]  lat,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic        mem_ube,
  input  wire logic        mem_lbe,
  input  wire logic [15:0] mem_wdata,
  output logic             mem_ack,
  output logic [15:0]      mem_rdata
);
  logic [15:0] mem [logic [31:0]];
  logic [15:0] word_v;
  logic [31:0] key_v;
  logic [1:0]  wait_r;
  logic [15:0] last_r;

  initial
  begin
    mem_ack   = 1'b0;
    mem_rdata = 16'h0;
    wait_r    = 2'h0;
    last_r    = 16'h0;
  end

  // Read data is valid only with the acknowledge; otherwise it toggles
  // every cycle, so a sample taken one cycle late cannot match by luck.
  always @(posedge ref_clk)
  begin
    mem_ack   <= 1'b0;
    mem_rdata <= ~last_r;
    last_r    <= ~last_r;
    if (mem_req && !mem_ack && wait_r >= lat)
    begin
      key_v  = {mem_addr[31:1], 1'b0};
      word_v = mem.exists(key_v) ? mem[key_v] : 16'h0;
      if (mem_we && mem_ube)
        word_v[15:8] = mem_wdata[15:8];
      if (mem_we && mem_lbe)
        word_v[7:0] = mem_wdata[7:0];
      if (mem_we)
        mem[key_v] = word_v;
      mem_ack   <= 1'b1;
      mem_rdata <= word_v;
      last_r    <= word_v;
      wait_r    <= 2'h0;
    end
    else
      wait_r <= (mem_req && !mem_ack) ? wait_r + 2'h1 : 2'h0;
  end
endmodule : csso_mem_model

//--- verif/cpu_stack_and_special_ops_tb.sv
// Self-checking bench for the stack and special-operation unit.
`timescale 1ns/1ps
module cpu_stack_and_special_ops_tb;
  import csso_pkg::*;
  logic        ref_clk, rst_b, cmd_valid, cmd_ready, rsp_valid;
  logic [3:0]  cmd_op;
  logic [1:0]  cmd_size, lat;
  logic [31:0] cmd_data, cmd_aux, rsp_data, addr_reg_seven, mem_addr;
  logic [2:0]  irq_level;
  logic [7:0]  rsp_frac;
  logic        unimpl_trap, low_power, supervisor, mem_req, mem_we;
  logic        mem_ube, mem_lbe, mem_ack;
  logic [15:0] mem_wdata, mem_rdata;
  logic [31:0] seed, w, l, p, a, sp;
  logic [39:0] t;
  logic [72:0] e;
  logic [72:0] qe [$];
  int          pending, n_fail, num_checks, traps, cyc, n;

  csso_core DUT (.ref_clk(ref_clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_size(cmd_size),
    .cmd_data(cmd_data), .cmd_aux(cmd_aux), .irq_level(irq_level),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_frac(rsp_frac),
    .unimpl_trap(unimpl_trap), .low_power(low_power),
    .supervisor(supervisor), .addr_reg_seven(addr_reg_seven),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_ube(mem_ube), .mem_lbe(mem_lbe), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  csso_mem_model mdl (.ref_clk(ref_clk), .lat(lat), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_ube(mem_ube),
    .mem_lbe(mem_lbe), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  always #12.5 ref_clk = ~ref_clk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Returns the fraction above the 32-bit interpolated value.
  function automatic logic [39:0] ip(longint y0, longint y1,
                                     logic [7:0] f, bit r);
    longint d;
    longint v;
    d = (y1 - y0) * f;
    v = r ? y0 + ((d + 128) >>> 8) : y0 + (d >>> 8);
    return {d[7:0], v[31:0]};
  endfunction : ip

  task finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      n_fail++;
    end
  endtask : chk

  // The expectation is queued before the request; wt waits for the answer.
  task send(input logic [3:0] op, input logic [1:0] sz, input logic [31:0] d,
            input logic [31:0] x, input logic [72:0] ex, input bit wt);
    n = 0;
    @(negedge ref_clk);
    lat = 2'(xs());
    qe.push_back(ex);
    pending++;
    cmd_op = op;
    cmd_size = sz;
    cmd_data = d;
    cmd_aux = x;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 500)
    begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    while (wt && pending != 0 && n < 500)
    begin
      @(negedge ref_clk);
      n++;
    end
    // A command that is never taken or answered ends the run as failed.
    if (n >= 500)
    begin
      n_fail++;
      finish_test();
    end
  endtask : send

  always @(negedge ref_clk)
  begin
    if (rst_b === 1'b1 && rsp_valid === 1'b1)
    begin
      // An answer that nobody asked for is a mismatch of its own.
      if (qe.size() == 0)
        chk(32'h1, 32'h0);
      else
      begin
        e = qe.pop_front();
        chk(rsp_data & e[63:32], e[31:0]);
        if (e[72])
          chk(rsp_frac, e[71:64]);
      end
      pending--;
    end
    if (unimpl_trap === 1'b1)
      traps++;
  end

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      finish_test();
    end
  end

  initial
  begin
    {ref_clk, rst_b, cmd_valid, cmd_op, cmd_size, lat} = '0;
    {cmd_data, cmd_aux, irq_level} = '0;
    {pending, n_fail, num_checks, traps, cyc} = '0;
    seed = 32'haf35;
    mdl.mem[32'h1000] = 16'h0010;
    mdl.mem[32'h1002] = 16'h5000;
    mdl.mem[32'h1004] = 16'h0100;
    mdl.mem[32'h1006] = 16'h0300;
    mdl.mem[32'h2000] = 16'h0001;
    mdl.mem[32'h2002] = 16'h0000;
    mdl.mem[32'h2004] = 16'h0003;
    mdl.mem[32'h2006] = 16'h0000;
    repeat (16) @(negedge ref_clk);
    rst_b = 1'b1;
    chk(supervisor, 1'b1);
    chk(addr_reg_seven, 32'h0);
    w = xs();
    l = xs();
    send(OP_PUSH, SZ_WORD, w, 0, 0, 1);
    chk(addr_reg_seven, 32'hfffffffe);
    send(OP_PUSH, SZ_LONG, l, 0, 0, 1);
    chk(addr_reg_seven, 32'hfffffffa);
    chk({mdl.mem[32'hfffffffa], mdl.mem[32'hfffffffc]}, l);
    send(OP_POP, SZ_LONG, 0, 0, {9'h0, ~32'h0, l}, 1);
    send(OP_POP, SZ_WORD, 0, 0, {9'h0, ~32'h0, 16'h0, w[15:0]}, 1);
    chk(addr_reg_seven, 32'h0);
    p = xs();
    send(OP_PUSH, SZ_BYTE, p, 0, 0, 1);
    chk(addr_reg_seven, 32'hfffffffe);
    chk(mdl.mem[32'hfffffffe], {p[7:0], w[7:0]});
    send(OP_POP, SZ_BYTE, 0, 0, {9'h0, ~32'h0, 24'h0, p[7:0]}, 1);
    chk(addr_reg_seven, 32'h0);
    $display("test stack done");
    send(OP_SETSW, 0, 32'h0, 0, 0, 1);
    chk(supervisor, 1'b0);
    send(OP_PUSH, SZ_WORD, w, 0, 0, 1);
    send(OP_SETSW, 0, 32'h2700, 0, 0, 1);
    chk(addr_reg_seven, 32'h0);
    send(OP_SETSW, 0, 32'h0, 0, 0, 1);
    chk(addr_reg_seven, 32'hfffffffe);
    p = xs();
    send(OP_CALL, 0, p, 0, 0, 1);
    chk({mdl.mem[32'hfffffffa], mdl.mem[32'hfffffffc]}, p);
    send(OP_RET, 0, 0, 0, {9'h0, ~32'h0, p}, 1);
    chk(addr_reg_seven, 32'hfffffffe);
    p = xs();
    send(OP_TRAP, 0, p, 0, 0, 1);
    chk(supervisor, 1'b1);
    chk(addr_reg_seven, 32'hfffffffa);
    chk(mdl.mem[32'hfffffffa], 32'h0);
    chk({mdl.mem[32'hfffffffc], mdl.mem[32'hfffffffe]}, p);
    $display("test modes done");
    for (int i = 0; i < 8; i++)
    begin
      a = xs();
      a[10:8] = i[2:0];
      send(OP_DECODE, 0, 32'h4e71, a,
           {9'h0, ~32'h0, 29'h0, a[8], a[10:9]}, 1);
    end
    chk(traps, 0);
    sp = 32'hfffffffa;
    for (int i = 0; i < 2; i++)
    begin
      p = xs();
      send(OP_DECODE, 0, i ? 32'hf7ff : 32'ha123, p, 0, 1);
      sp = sp - 32'h6;
      chk(mdl.mem[sp + 32'h4], p[15:0]);
    end
    // An undefined command is answered with zero and raises no trap.
    send(4'hb, 0, xs(), 0, {9'h0, ~32'h0, 32'h0}, 1);
    chk(traps, 2);
    chk(addr_reg_seven, sp);
    $display("test decode done");
    p = xs();
    send(OP_HALT, 0, p, 32'h3, 0, 0);
    @(negedge ref_clk);
    chk(low_power, 1'b1);
    irq_level = 3'h2;
    repeat (10) @(negedge ref_clk);
    chk(low_power, 1'b1);
    irq_level = 3'h5;
    n = 0;
    while (pending != 0 && n < 500)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 500)
    begin
      n_fail++;
      finish_test();
    end
    irq_level = 3'h0;
    sp = sp - 32'h6;
    chk(low_power, 1'b0);
    chk(mdl.mem[sp][13], 1'b1);
    chk({mdl.mem[sp + 32'h2], mdl.mem[sp + 32'h4]}, p);
    chk(addr_reg_seven, sp);
    $display("test standby done");
    a = xs();
    t = ip(16, 80, a[7:0], 0);
    send(OP_TABLE, SZ_BYTE, 32'h1001, {24'h0, a[7:0]},
         {1'b1, t[39:32], 32'hff, t[31:0]}, 1);
    t = ip(256, 768, a[7:0], 1);
    send(OP_TABLE, SZ_WORD, 32'h1004, {23'h0, 1'b1, a[7:0]},
         {9'h0, 32'hffff, t[31:0]}, 1);
    t = ip(32'h10000, 32'h30000, a[7:0], 1);
    send(OP_TABLE, SZ_LONG, 32'h2000, {24'h0, a[7:0]},
         {9'h0, ~32'h0, t[31:0]}, 1);
    $display("test table done");
    send(OP_HALT, 0, p, 32'h7, 0, 0);
    @(negedge ref_clk);
    rst_b = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(low_power, 1'b0);
    qe.delete();
    pending = 0;
    rst_b = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk(cmd_ready, 1'b1);
    chk(addr_reg_seven, 32'h0);
    chk(supervisor, 1'b1);
    $display("test reset done");
    finish_test();
  end
endmodule : cpu_stack_and_special_ops_tb
